// file: logic/clmp_pkg.sv
// Constants shared by the core local memory access protection block
// Function
// - Both level-1 memories reset to all cache
// - Data L1 two-way, program L1 direct-mapped
// - Level-2 split by mode, resets all SRAM
// - Core owns 512KB level-2 at local 0080_0000h
// - Own-core alias address maps to global location
// - Global level-2 base per core, all masters
// - Shared SRAM always SRAM, always L1-cacheable, L2 cacheability by mode
// - External addresses extended from 2GB to 8GB
// - Pages: 16x2KB per L1, 32x16KB level-2
// - Separate user/supervisor read/write/execute permission bits
// - Direct DSP and CCO are local; DMA, masters global
// - Page system/local bits decode access classes
// - Secure device: pages secure-only until opened
// - Every access carries a privilege identifier
// - Blocked read returns zero, write discarded
// - Fault records initiator, address, access type
// - Fault raises event to interrupt controller
// - Arbiter grants highest-priority contending requestor
// - Core and system priority registers set priorities
// - Power-down L1P, cache, DSP, core; no L2
// - Read-only version register, version and revision
// - Lower priority value is more urgent
`default_nettype none
package clmp_pkg;
    // -------------------------------------------------------------------
    // Requestors
    // -------------------------------------------------------------------
    localparam int NREQ = 4;
    localparam int REQ_DSP = 0;
    localparam int REQ_CCO = 1;
    localparam int REQ_INTERNAL_DMA = 2;
    localparam int REQ_SYS = 3;
    localparam int PRI_W = 3;
    localparam int PRI_STRIDE = 4;
    localparam int PRIV_W = 8;
    localparam logic [2:0] PRI_RST = 3'h7;
    // -------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------
    localparam logic [31:0] A_VER = 32'h0181_2000;
    localparam logic [31:0] A_CFG = 32'h0181_2004;
    localparam logic [31:0] A_CPRI = 32'h0181_2008;
    localparam logic [31:0] A_SPRI = 32'h0181_200c;
    localparam logic [31:0] A_FADDR = 32'h0181_2010;
    localparam logic [31:0] A_FINFO = 32'h0181_2014;
    localparam logic [31:0] A_FCLR = 32'h0181_2018;
    localparam logic [31:0] A_PWR = 32'h0181_201c;
    localparam logic [23:0] A_PAGE_HI = 24'h0184_a0;
    // Arbitrary neutral identity values
    localparam logic [15:0] CORE_VERSION = 16'h0001;
    localparam logic [15:0] CORE_REVISION = 16'h0000;
    // Configuration fields
    localparam int CFG_P1 = 0;
    localparam int CFG_D1 = 4;
    localparam int CFG_L2 = 8;
    localparam int CFG_L3M = 12;
    localparam int CFG_EXT = 13;
    localparam int CFG_WAYS = 16;
    localparam logic [2:0] L1_ALL_CACHE = 3'h4;
    localparam logic [2:0] L2_ALL_SRAM = 3'h0;
    localparam logic [3:0] L1D_WAYS = 4'h2;
    localparam logic [3:0] L1P_WAYS = 4'h1;
    localparam logic [3:0] L2_WAYS = 4'h4;
    // Fault info fields
    localparam int FI_VALID = 0;
    localparam int FI_TYPE = 1;
    localparam int FI_SUP = 3;
    localparam int FI_ALIAS = 4;
    localparam int FI_PRIV = 8;
    localparam int FI_REQ = 16;
    // -------------------------------------------------------------------
    // Address map of one core
    // -------------------------------------------------------------------
    localparam logic [7:0] GLOBAL_HI0 = 8'h10;
    localparam logic [7:0] ALIAS_HI = 8'h00;
    localparam logic [4:0] L2_SEL = 5'h10;
    localparam logic [8:0] L1P_SEL = 9'h1c0;
    localparam logic [8:0] L1D_SEL = 9'h1e0;
    localparam logic [9:0] MSM_SEL = 10'h030;
    // -------------------------------------------------------------------
    // Page attributes
    // -------------------------------------------------------------------
    localparam int NPAGE = 64;
    localparam int ATTR_W = 11;
    localparam int AT_LOCAL = 8;
    localparam int AT_SYS = 9;
    localparam int AT_PUBLIC = 10;
    localparam int PERM_SUP = 3;
    localparam logic [10:0] ATTR_RST = 11'h33f;
    localparam bit SECURE_DEVICE = 1'b1;
    localparam logic [1:0] TYPE_RD = 2'h0;
    localparam logic [1:0] TYPE_WR = 2'h1;
    localparam logic [1:0] TYPE_EX = 2'h2;
endpackage
`default_nettype wire

// file: logic/clmp_core_mem_guard.sv
// Core local memory arbitration, address aliasing and page protection
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module clmp_core_mem_guard #(
    parameter logic [0:0] CORE_ID = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [3:0] req_valid,
    input wire logic [3:0][31:0] req_addr,
    input wire logic [3:0] req_write,
    input wire logic [3:0] req_exec,
    input wire logic [3:0] req_super,
    input wire logic [3:0] req_secure,
    input wire logic [3:0][7:0] req_priv,
    input wire logic [31:0] mem_rdata,
    output logic [3:0] acc_grant,
    output logic mem_req,
    output logic mem_we,
    output logic [32:0] mem_addr,
    output logic mem_l1_cacheable,
    output logic mem_l2_cacheable,
    output logic acc_fault,
    output logic acc_rvalid,
    output logic [31:0] acc_rdata,
    output logic fault_event,
    output logic [2:0] prog_l1_split_field,
    output logic [2:0] data_l1_split_field,
    output logic [2:0] level2_split_field,
    output logic pd_l1p,
    output logic pd_cache_ctl,
    output logic pd_dsp,
    output logic pd_core
);
    localparam logic [7:0] CORE_HI = clmp_pkg::GLOBAL_HI0 + {7'h00, CORE_ID};

    logic [11:0] core_pri;
    logic [2:0] sys_pri;
    logic msm_l3_mode;
    logic [1:0] ext_seg;
    logic [31:0] fault_addr;
    logic [23:0] fault_info;
    logic [3:0] pwr;
    logic [clmp_pkg::ATTR_W-1:0] attr [clmp_pkg::NPAGE];
    logic [3:0][2:0] req_pri;
    logic [3:0] win;
    logic any_valid;
    logic rd_pend;
    logic rd_ok;

    // -------------------------------------------------------------------
    // APB slave
    // -------------------------------------------------------------------
    // One wait state: pready rises on the second access cycle
    logic apb_wr;
    logic apb_page;
    logic [5:0] apb_pidx;
    logic [31:0] rd_mux;
    logic rd_err;
    logic fault_set;
    logic [31:0] cfg_word;

    assign apb_wr = psel & penable & pready & pwrite;
    assign apb_page = paddr[31:8] == clmp_pkg::A_PAGE_HI;
    assign apb_pidx = paddr[7:2];

    always_comb begin
        cfg_word = 32'h0000_0000;
        cfg_word[clmp_pkg::CFG_P1 +: 3] = prog_l1_split_field;
        cfg_word[clmp_pkg::CFG_D1 +: 3] = data_l1_split_field;
        cfg_word[clmp_pkg::CFG_L2 +: 3] = level2_split_field;
        cfg_word[clmp_pkg::CFG_L3M] = msm_l3_mode;
        cfg_word[clmp_pkg::CFG_EXT +: 2] = ext_seg;
        // Associativity is fixed by the cache structure
        cfg_word[clmp_pkg::CFG_WAYS +: 12] = {clmp_pkg::L2_WAYS,
            clmp_pkg::L1D_WAYS, clmp_pkg::L1P_WAYS};
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        if (apb_page) begin
            rd_mux[clmp_pkg::ATTR_W-1:0] = attr[apb_pidx];
        end else begin
            case (paddr)
                clmp_pkg::A_VER: rd_mux = {clmp_pkg::CORE_VERSION,
                    clmp_pkg::CORE_REVISION};
                clmp_pkg::A_CFG: rd_mux = cfg_word;
                clmp_pkg::A_CPRI: rd_mux[11:0] = core_pri;
                clmp_pkg::A_SPRI: rd_mux[2:0] = sys_pri;
                clmp_pkg::A_FADDR: rd_mux = fault_addr;
                clmp_pkg::A_FINFO: rd_mux[23:0] = fault_info;
                clmp_pkg::A_FCLR: rd_mux = 32'h0000_0000;
                clmp_pkg::A_PWR: rd_mux[3:0] = pwr;
                default: rd_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            prdata <= (psel & penable & ~pready & ~pwrite) ? rd_mux
                : 32'h0000_0000;
            pslverr <= psel & penable & ~pready & rd_err;
        end
    end

    // -------------------------------------------------------------------
    // Control registers
    // -------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_l1_split_field <= clmp_pkg::L1_ALL_CACHE;
            data_l1_split_field <= clmp_pkg::L1_ALL_CACHE;
            level2_split_field <= clmp_pkg::L2_ALL_SRAM;
            msm_l3_mode <= 1'b0;
            ext_seg <= 2'h0;
        end else if (apb_wr && paddr == clmp_pkg::A_CFG) begin
            prog_l1_split_field <= pwdata[clmp_pkg::CFG_P1 +: 3];
            data_l1_split_field <= pwdata[clmp_pkg::CFG_D1 +: 3];
            level2_split_field <= pwdata[clmp_pkg::CFG_L2 +: 3];
            msm_l3_mode <= pwdata[clmp_pkg::CFG_L3M];
            ext_seg <= pwdata[clmp_pkg::CFG_EXT +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_pri <= {1'b0, clmp_pkg::PRI_RST, 1'b0, clmp_pkg::PRI_RST,
                1'b0, clmp_pkg::PRI_RST};
            sys_pri <= clmp_pkg::PRI_RST;
        end else if (apb_wr && paddr == clmp_pkg::A_CPRI) begin
            core_pri <= pwdata[11:0] & 12'h777;
        end else if (apb_wr && paddr == clmp_pkg::A_SPRI) begin
            sys_pri <= pwdata[2:0];
        end
    end

    // No level-2 power-down bit exists in this register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr <= 4'h0;
        end else if (apb_wr && paddr == clmp_pkg::A_PWR) begin
            pwr <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_l1p <= 1'b0;
            pd_cache_ctl <= 1'b0;
            pd_dsp <= 1'b0;
            pd_core <= 1'b0;
        end else begin
            pd_l1p <= pwr[0];
            pd_cache_ctl <= pwr[1];
            pd_dsp <= pwr[2];
            pd_core <= pwr[3];
        end
    end

    // -------------------------------------------------------------------
    // Page attribute table and requestor priorities
    // -------------------------------------------------------------------
    // Pages 0-15 program L1, 16-31 data L1, 32-63 level-2
    genvar gi;
    generate
        for (gi = 0; gi < clmp_pkg::NPAGE; gi++) begin : g_page
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    attr[gi] <= clmp_pkg::ATTR_RST;
                end else if (apb_wr && apb_page && apb_pidx == gi) begin
                    attr[gi] <= pwdata[clmp_pkg::ATTR_W-1:0];
                end
            end
        end
        for (gi = 0; gi < clmp_pkg::NREQ; gi++) begin : g_req
            if (gi == clmp_pkg::REQ_SYS) begin : g_s
                assign req_pri[gi] = sys_pri;
            end else begin : g_c
                assign req_pri[gi] =
                    core_pri[gi*clmp_pkg::PRI_STRIDE +: clmp_pkg::PRI_W];
            end
        end
    endgenerate

    // -------------------------------------------------------------------
    // Arbitration
    // -------------------------------------------------------------------
    // Lowest value wins; ties go to the lowest requestor index
    always_comb begin
        logic [2:0] best;
        best = clmp_pkg::PRI_RST;
        win = 4'h0;
        for (int i = 0; i < clmp_pkg::NREQ; i++) begin
            if (req_valid[i] && (win == 4'h0 || req_pri[i] < best)) begin
                best = req_pri[i];
                win = 4'h0;
                win[i] = 1'b1;
            end
        end
    end
    assign any_valid = |req_valid;

    // -------------------------------------------------------------------
    // Address translation and permission check
    // -------------------------------------------------------------------
    logic [31:0] w_addr;
    logic w_wr;
    logic w_ex;
    logic w_sup;
    logic w_sec;
    logic [7:0] w_priv;
    logic [1:0] w_idx;
    logic w_local;
    logic w_alias;
    logic alias_bad;
    logic [31:0] g_addr;
    logic in_page;
    logic [5:0] pidx;
    logic [1:0] w_type;
    logic [clmp_pkg::ATTR_W-1:0] pat;
    logic class_ok;
    logic perm_ok;
    logic sec_ok;
    logic acc_ok;

    always_comb begin
        w_idx = 2'h0;
        for (int i = 0; i < clmp_pkg::NREQ; i++) begin
            if (win[i]) begin
                w_idx = i[1:0];
            end
        end
    end

    assign w_addr = req_addr[w_idx];
    assign w_wr = req_write[w_idx];
    assign w_ex = req_exec[w_idx] & ~w_wr;
    assign w_sup = req_super[w_idx];
    assign w_sec = req_secure[w_idx];
    assign w_priv = req_priv[w_idx];
    // DMA work set up by the DSP still arrives on a DMA port
    assign w_local = (w_idx == clmp_pkg::REQ_DSP[1:0]) ||
        (w_idx == clmp_pkg::REQ_CCO[1:0]);
    assign w_alias = w_addr[31:24] == clmp_pkg::ALIAS_HI;
    assign alias_bad = w_alias & ~w_local;
    assign g_addr = (w_alias && w_local) ?
        {CORE_HI, w_addr[23:0]} : w_addr;
    assign w_type = w_wr ? clmp_pkg::TYPE_WR :
        (w_ex ? clmp_pkg::TYPE_EX : clmp_pkg::TYPE_RD);

    always_comb begin
        in_page = 1'b0;
        pidx = 6'h00;
        if (g_addr[31:24] == CORE_HI) begin
            if (g_addr[23:19] == clmp_pkg::L2_SEL) begin
                in_page = 1'b1;
                pidx = {1'b1, g_addr[18:14]};
            end else if (g_addr[23:15] == clmp_pkg::L1P_SEL) begin
                in_page = 1'b1;
                pidx = {2'b00, g_addr[14:11]};
            end else if (g_addr[23:15] == clmp_pkg::L1D_SEL) begin
                in_page = 1'b1;
                pidx = {2'b01, g_addr[14:11]};
            end
        end
    end

    assign pat = attr[pidx];
    assign class_ok = w_local ? pat[clmp_pkg::AT_LOCAL]
        : pat[clmp_pkg::AT_SYS];
    assign perm_ok = pat[(w_sup ? clmp_pkg::PERM_SUP : 0) +
        int'(w_type)];
    assign sec_ok = ~clmp_pkg::SECURE_DEVICE | w_sec |
        pat[clmp_pkg::AT_PUBLIC];
    assign acc_ok = ~alias_bad &
        (~in_page | (class_ok & perm_ok & sec_ok));

    // -------------------------------------------------------------------
    // Access result stage
    // -------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_grant <= 4'h0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 33'h0_0000_0000;
            mem_l1_cacheable <= 1'b0;
            mem_l2_cacheable <= 1'b0;
            acc_fault <= 1'b0;
            fault_event <= 1'b0;
            rd_pend <= 1'b0;
            rd_ok <= 1'b0;
        end else begin
            acc_grant <= win;
            mem_req <= any_valid & acc_ok;
            mem_we <= any_valid & acc_ok & w_wr;
            // External window: segment bits reach the upper 6GB
            mem_addr <= g_addr[31] ? {ext_seg, g_addr[30:0]}
                : {1'b0, g_addr};
            mem_l1_cacheable <= g_addr[31:22] == clmp_pkg::MSM_SEL;
            mem_l2_cacheable <= (g_addr[31:22] == clmp_pkg::MSM_SEL)
                & msm_l3_mode;
            acc_fault <= any_valid & ~acc_ok;
            fault_event <= any_valid & ~acc_ok;
            rd_pend <= any_valid & ~w_wr;
            rd_ok <= acc_ok;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_rvalid <= 1'b0;
            acc_rdata <= 32'h0000_0000;
        end else begin
            acc_rvalid <= rd_pend;
            acc_rdata <= (rd_pend & rd_ok) ? mem_rdata
                : 32'h0000_0000;
        end
    end

    // -------------------------------------------------------------------
    // Fault capture
    // -------------------------------------------------------------------
    // First fault is held until cleared; a new fault wins over a clear
    assign fault_set = any_valid & ~acc_ok &
        (~fault_info[clmp_pkg::FI_VALID] |
        (apb_wr & paddr == clmp_pkg::A_FCLR & pwdata[0]));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_addr <= 32'h0000_0000;
            fault_info <= 24'h00_0000;
        end else if (fault_set) begin
            fault_addr <= w_addr;
            fault_info <= {6'h00, w_idx, w_priv, 3'h0, alias_bad, w_sup,
                w_type, 1'b1};
        end else if (apb_wr && paddr == clmp_pkg::A_FCLR && pwdata[0]) begin
            fault_info[clmp_pkg::FI_VALID] <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    blk_read_zero_a: assert property (
        acc_fault && rd_pend |=> acc_rvalid && acc_rdata == 32'h0000_0000)
        else $error("blocked read returned data");
    blk_write_a: assert property (
        acc_fault |-> !mem_req && !mem_we)
        else $error("blocked access reached memory");
    fault_capture_a: assert property (
        acc_fault |-> fault_info[clmp_pkg::FI_VALID])
        else $error("fault not captured");
    fault_event_a: assert property (
        any_valid && !acc_ok |=> fault_event ##1
        (!fault_event || $past(any_valid)))
        else $error("fault event missing");
    grant_one_a: assert property (
        any_valid |=> $onehot(acc_grant) && (acc_grant & $past(req_valid))
        == acc_grant)
        else $error("grant not one valid requestor");
    grant_prio_a: assert property (
        req_valid[0] && req_valid[3] && req_pri[0] < req_pri[3]
        |=> !acc_grant[3])
        else $error("less urgent requestor granted");
    version_read_a: assert property (
        psel && penable && !pready && !pwrite && paddr == clmp_pkg::A_VER
        |=> pready && prdata == {clmp_pkg::CORE_VERSION,
        clmp_pkg::CORE_REVISION})
        else $error("version read wrong");
    alias_map_a: assert property (
        req_valid == 4'h1 && req_addr[0][31:24] == clmp_pkg::ALIAS_HI
        |=> mem_addr[31:24] == CORE_HI || acc_fault)
        else $error("alias not mapped to own core");
endmodule // clmp_core_mem_guard
`default_nettype wire

// file: tb/clmp_mem_model.sv
// Behavioural memory that answers granted reads behind the guard
`timescale 1ns/100ps
`default_nettype none
module clmp_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [32:0] mem_addr,
    output logic [31:0] mem_rdata
);
    logic [31:0] last;
    logic rd_now;
    assign rd_now = mem_req && !mem_we;
    // Idle bus shows the inverse of the last word, so stale data never passes
    assign mem_rdata = rd_now ? (mem_addr[31:0] ^ 32'ha5a5_0000) : ~last;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= 32'h0000_0000;
        end else begin
            last <= mem_rdata;
        end
    end
endmodule // clmp_mem_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking testbench of the core memory guard
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, mem_rdata, acc_rdata, rd, rd_s;
    logic [3:0] req_valid, req_write, req_exec, req_super, req_secure;
    logic [3:0] acc_grant, g_s;
    logic [3:0][31:0] req_addr;
    logic [3:0][7:0] req_priv;
    logic mem_req, mem_we, acc_fault, acc_rvalid, fault_event;
    logic f_s, ev_s, mr_s, rv_s, mem_l1_cacheable, mem_l2_cacheable;
    logic [1:0] cc_s;
    logic [32:0] mem_addr, ma_s;
    logic [2:0] prog_l1_split_field, data_l1_split_field, level2_split_field;
    logic pd_l1p, pd_cache_ctl, pd_dsp, pd_core;
    int n_fail = 0;
    int samples_checked = 0;
    clmp_core_mem_guard #(.CORE_ID(1'b0)) clmp_core_mem_guard_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .req_valid, .req_addr, .req_write, .req_exec,
        .req_super, .req_secure, .req_priv, .mem_rdata, .acc_grant, .mem_req,
        .mem_we, .mem_addr, .mem_l1_cacheable, .mem_l2_cacheable,
        .acc_fault, .acc_rvalid, .acc_rdata, .fault_event,
        .prog_l1_split_field, .data_l1_split_field, .level2_split_field,
        .pd_l1p, .pd_cache_ctl, .pd_dsp, .pd_core);
    clmp_mem_model clmp_mem_model_inst (.pclk, .presetn, .mem_req, .mem_we,
        .mem_addr, .mem_rdata);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            n_fail++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Same request from every requestor in v; outputs sampled mid-cycle
    task automatic acc(input logic [3:0] v, input logic [31:0] a,
                       input logic w, s, sec);
        @(posedge pclk);
        req_valid <= v;
        req_addr <= {4{a}};
        req_write <= {4{w}};
        req_super <= {4{s}};
        req_secure <= {4{sec}};
        @(posedge pclk);
        req_valid <= 4'h0;
        @(negedge pclk);
        g_s = acc_grant;
        f_s = acc_fault;
        ev_s = fault_event;
        mr_s = mem_req;
        ma_s = mem_addr;
        cc_s = {mem_l2_cacheable, mem_l1_cacheable};
        @(negedge pclk);
        rv_s = acc_rvalid;
        rd_s = acc_rdata;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic s_reset();
        chk("l1p split", 32'(prog_l1_split_field), 32'h4);
        chk("l1d split", 32'(data_l1_split_field), 32'h4);
        chk("l2 split", 32'(level2_split_field), 32'h0);
        apb(1'b1, clmp_pkg::A_VER, 32'hffff_ffff);
        apb(1'b0, clmp_pkg::A_VER, 32'h0);
        chk("version", rd, 32'h0001_0000);
        apb(1'b0, clmp_pkg::A_CFG, 32'h0);
        chk("cfg", rd, 32'h0421_0044);
        apb(1'b1, clmp_pkg::A_CFG, 32'h0000_0123);
        @(negedge pclk);
        chk("split", 32'({prog_l1_split_field, data_l1_split_field,
            level2_split_field}), 32'h0000_00d1);
        apb(1'b0, 32'h0184_a080, 32'h0);
        chk("attr", rd, 32'h0000_033f);
        apb(1'b0, 32'h0181_3000, 32'h0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
    endtask
    task automatic s_alias();
        acc(4'h1, 32'h0080_0010, 1'b0, 1'b0, 1'b1);
        chk("alias", ma_s[31:0], 32'h1080_0010);
        chk("alias data", rd_s, 32'hb525_0010);
        acc(4'h1, 32'h0080_0010, 1'b0, 1'b0, 1'b0);
        chk("nonsecure", {f_s, ev_s, rv_s}, 32'h7);
        chk("blocked rd", rd_s, 32'h0);
        acc(4'h4, 32'h0080_0010, 1'b0, 1'b0, 1'b1);
        chk("internal_dma alias", 32'(f_s), 32'h1);
    endtask
    task automatic s_fault();
        apb(1'b1, clmp_pkg::A_FCLR, 32'h1);
        acc(4'h4, 32'h1080_0040, 1'b1, 1'b1, 1'b0);
        chk("blocked wr", 32'(mr_s), 32'h0);
        acc(4'h1, 32'h1080_0080, 1'b0, 1'b0, 1'b0);
        apb(1'b0, clmp_pkg::A_FADDR, 32'h0);
        chk("faddr", rd, 32'h1080_0040);
        apb(1'b0, clmp_pkg::A_FINFO, 32'h0);
        chk("finfo", rd, 32'h0002_420b);
        apb(1'b1, clmp_pkg::A_FCLR, 32'h1);
        apb(1'b0, clmp_pkg::A_FINFO, 32'h0);
        chk("cleared", 32'(rd[0]), 32'h0);
    endtask
    task automatic s_decode();
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, 32'h0184_a080, {22'h0, 1'(k >> 1), 1'(k), 8'h3f});
            for (int j = 0; j < 2; j++) begin
                acc(j ? 4'h4 : 4'h1, 32'h1080_0000, 1'b0, 1'b0, 1'b1);
                chk("decode", 32'(mr_s), 32'(k >> j & 1));
                chk("dfault", 32'(f_s), 32'(~k >> j & 1));
            end
        end
    endtask
    task automatic s_perm();
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, 32'h0184_a080, p ? 32'h0000_0338 : 32'h0000_0307);
            for (int s = 0; s < 2; s++) begin
                acc(4'h1, 32'h1080_0100, 1'(s), 1'(s), 1'b1);
                chk("perm", 32'(f_s), 32'(s != p));
            end
        end
        apb(1'b1, 32'h0184_a080, 32'h0000_033f);
    endtask
    task automatic s_arb();
        apb(1'b1, clmp_pkg::A_CPRI, 32'h0000_0153);
        apb(1'b1, clmp_pkg::A_SPRI, 32'h1);
        acc(4'hf, 32'h1080_0000, 1'b0, 1'b0, 1'b1);
        chk("grant tie", 32'(g_s), 32'h4);
        apb(1'b1, clmp_pkg::A_SPRI, 32'h0);
        acc(4'hf, 32'h1080_0000, 1'b0, 1'b0, 1'b1);
        chk("grant sys", 32'(g_s), 32'h8);
        apb(1'b1, clmp_pkg::A_CPRI, 32'h0000_0777);
        apb(1'b1, clmp_pkg::A_SPRI, 32'h7);
        acc(4'he, 32'h1080_0000, 1'b0, 1'b0, 1'b1);
        chk("grant low", 32'(g_s), 32'h2);
        apb(1'b1, clmp_pkg::A_CPRI, 32'h0000_0776);
        acc(4'h9, 32'h1080_0000, 1'b0, 1'b0, 1'b1);
        chk("grant dsp", 32'(g_s), 32'h1);
    endtask
    task automatic s_pwr();
        apb(1'b1, clmp_pkg::A_PWR, 32'h0000_000a);
        // Power-down outputs follow the register one cycle later
        repeat (2) @(negedge pclk);
        chk("power", 32'({pd_core, pd_dsp, pd_cache_ctl, pd_l1p}),
            32'ha);
    endtask
    task automatic s_msm();
        acc(4'h1, 32'h0c00_0040, 1'b0, 1'b0, 1'b1);
        chk("msm l2", 32'(cc_s), 32'h1);
        apb(1'b1, clmp_pkg::A_CFG, 32'h0000_5123);
        acc(4'h1, 32'h0c00_0040, 1'b0, 1'b0, 1'b1);
        chk("msm l3", 32'(cc_s), 32'h3);
        acc(4'h1, 32'h8000_0010, 1'b0, 1'b0, 1'b1);
        chk("ext seg", 32'(ma_s[32:31]), 32'h2);
    endtask
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        req_valid = 4'h0;
        req_addr = '0;
        req_write = 4'h0;
        req_exec = 4'h0;
        req_super = 4'h0;
        req_secure = 4'h0;
        req_priv = {8'h43, 8'h42, 8'h41, 8'h40};
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        s_reset();
        s_alias();
        s_fault();
        s_decode();
        s_perm();
        s_arb();
        s_pwr();
        s_msm();
        wrap_up();
    end
endmodule // tb
`default_nettype wire
